// >>> design/pin_sync3.sv
`timescale 1ns/1ps

// ==================================================
// Three-stage pin synchroniser with agreement filter
// ==================================================
module pin_sync3 (
   input  wire logic clk_i,    // System clock
   input  wire logic rst_i,    // Sync reset, active high
   input  wire logic pin_i,    // Asynchronous pin
   output logic      rise_o    // One-cycle pulse per accepted rise
);

   logic stage1_reg;   // Metastability catcher, read by stage2 only
   logic stage2_reg;   // Second stage
   logic stage3_reg;   // Third stage
   logic level_reg;    // Accepted level

   // Shift chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end else begin
         stage1_reg <= pin_i;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // Level only moves when two late stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_reg <= 1'b0;
         rise_o    <= 1'b0;
      end else begin
         if (stage2_reg == stage3_reg) begin
            level_reg <= stage3_reg;
         end
         rise_o <= (stage2_reg == stage3_reg) & stage3_reg & ~level_reg;
      end
   end

endmodule : pin_sync3

// >>> design/rtc_control_status.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "rtc_ctrl_params.svh"

module rtc_control_status #(
   parameter int ADR_W = 10   // Wishbone byte address width
) (
   // ==================================================
   // Clock and resets
   // ==================================================
   input  wire logic             clk_i,          // System clock, 20 MHz
   input  wire logic             rst_i,          // System reset, sync
   input  wire logic             por_i,          // Power-on reset, sync
   // ==================================================
   // Wishbone slave
   // ==================================================
   input  wire logic             wb_cyc_i,       // Bus cycle
   input  wire logic             wb_stb_i,       // Strobe
   input  wire logic             wb_we_i,        // Write enable
   input  wire logic [ADR_W-1:0] wb_adr_i,       // Byte address
   input  wire logic [3:0]       wb_sel_i,       // Byte lanes
   input  wire logic [31:0]      wb_dat_i,       // Write data
   output logic      [31:0]      wb_dat_o,       // Read data
   output logic                  wb_ack_o,       // Acknowledge
   // ==================================================
   // Time sources
   // ==================================================
   input  wire logic             xtal_clk_i,     // 32768 Hz crystal output
   input  wire logic             line_freq_i,    // Power-line input
   output logic                  osc_enable_o,   // Crystal oscillator on
   // ==================================================
   // Count and alarm side
   // ==================================================
   input  wire logic [3:0]       field_match_i,  // Per-field equality
   input  wire logic             wake_reset_i,   // Sleep recovery reset
   output logic                  count_tick_o,   // One-second increment
   output logic                  count_write_permit_o, // Count writes ok
   output logic                  bcd_mode_o,     // Decimal counting
   output logic      [3:0]       match_enable_o, // Alarm field enables
   output logic                  alarm_irq_o     // Alarm request
);

   // ==================================================
   // Register state
   // ==================================================
   logic       alarm_reg;        // Pending alarm flag
   logic       int_en_reg;       // Alarm interrupt enable
   logic       bcd_reg;          // Decimal count select
   logic       src_sel_reg;      // Time source select
   logic       mains_rate_reg;   // Mains rate select
   logic       sleep_cause_reg;  // Alarm caused the wake
   logic       unlock_reg;       // Count write permit
   logic       unlock_d_reg;     // Permit of last cycle
   logic [3:0] match_en_reg;     // Per-field alarm enables
   logic       tick_d_reg;       // Count increment landed

   // ==================================================
   // Bus decode
   // ==================================================
   logic       req;              // Live request, not yet answered
   logic       hit_ctrl;         // Control register selected
   logic       hit_match;        // Match control selected
   logic       wr_ctrl;          // Accepted control write
   logic       wr_match;         // Accepted match write
   logic       rd_ctrl;          // Accepted control read
   logic [7:0] ctrl_view;        // Control byte as read
   logic [7:0] wdat;             // Low write lane

   // A request is taken on the edge that raises ack
   assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_ctrl  = (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(`RTC_CONTROL_IDX))
                      & (wb_adr_i[1:0] == 2'h0);
   assign hit_match = (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(`RTC_ALARM_MATCH_IDX))
                      & (wb_adr_i[1:0] == 2'h0);
   // Only lane 0 carries the byte wide registers
   assign wr_ctrl   = req & wb_we_i & hit_ctrl & wb_sel_i[0];
   assign wr_match  = req & wb_we_i & hit_match & wb_sel_i[0];
   // Reads clear flags whatever the lanes, the access itself counts
   assign rd_ctrl   = req & ~wb_we_i & hit_ctrl;
   assign wdat      = wb_dat_i[7:0];

   // ==================================================
   // Time base
   // ==================================================
   logic                   xtal_rise;   // Accepted crystal edge
   logic                   line_rise;   // Accepted line edge
   logic                   step;        // Edge of chosen source
   logic                   sec_tick;    // One second elapsed
   rtc_ctrl_pkg::prescale_t divisor;    // Edges per second

   // Both pins are outside this clock domain
   pin_sync3 u_xtal_sync (
      .clk_i  (clk_i),
      .rst_i  (por_i),
      .pin_i  (xtal_clk_i),
      .rise_o (xtal_rise)
   );

   pin_sync3 u_line_sync (
      .clk_i  (clk_i),
      .rst_i  (por_i),
      .pin_i  (line_freq_i),
      .rise_o (line_rise)
   );

   // Pick edge stream and divisor from the source bits
   always_comb begin
      if (src_sel_reg == rtc_ctrl_pkg::SRC_LINE) begin
         step = line_rise;
         if (mains_rate_reg == rtc_ctrl_pkg::MAINS_50) begin
            divisor = `RTC_MAINS_50_HZ;
         end else begin
            divisor = `RTC_MAINS_60_HZ;
         end
      end else begin
         // Crystal edges ignored while the line is chosen
         step    = xtal_rise;
         divisor = `RTC_XTAL_HZ;
      end
   end

   // Any control write restarts the divide for alignment
   rtc_prescaler #(
      .W (16)
   ) u_prescaler (
      .clk_i     (clk_i),
      .rst_i     (por_i),
      .clear_i   (wr_ctrl),
      .step_i    (step),
      .divisor_i (divisor),
      .tick_o    (sec_tick)
   );

   // ==================================================
   // Alarm condition
   // ==================================================
   logic [3:0] field_ok;     // Field passes or is not watched
   logic       alarm_cond;   // Every watched field matches
   logic       eval_now;     // Moment to look at the condition

   // A field outside the enable mask never blocks the alarm
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_field
         assign field_ok[g] = ~match_en_reg[g] | field_match_i[g];
      end
   endgenerate

   // With no field enabled the alarm stays silent
   assign alarm_cond = (|match_en_reg) & (&field_ok);

   // Counts settle one cycle after the tick, so look then.
   // Locking also triggers a look, catching a fresh set time.
   assign eval_now = tick_d_reg | (unlock_d_reg & ~unlock_reg);

   // ==================================================
   // Alarm flag
   // ==================================================
   // Survives system reset; of the two resets only power-on clears it.
   // Set beats a clearing read in the same cycle.
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         alarm_reg <= 1'b0;
      end else if (eval_now && alarm_cond) begin
         alarm_reg <= 1'b1;
      end else if (rd_ctrl) begin
         alarm_reg <= 1'b0;
      end
   end

   // ==================================================
   // Bits that system reset defines
   // ==================================================
   always_ff @(posedge clk_i) begin
      if (por_i || rst_i) begin
         int_en_reg <= `RTC_RST_INT_EN;
         unlock_reg <= `RTC_RST_UNLOCK;
      end else if (wr_ctrl) begin
         int_en_reg <= wdat[`RTC_BIT_INT_EN];
         unlock_reg <= wdat[`RTC_BIT_UNLOCK];
      end
   end

   // ==================================================
   // Bits that system reset leaves alone
   // ==================================================
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         bcd_reg        <= 1'b0;
         src_sel_reg    <= rtc_ctrl_pkg::SRC_XTAL;
         mains_rate_reg <= rtc_ctrl_pkg::MAINS_60;
      end else if (wr_ctrl) begin
         // No rst_i term here on purpose
         bcd_reg        <= wdat[`RTC_BIT_BCD];
         src_sel_reg    <= wdat[`RTC_BIT_SRC_SEL];
         mains_rate_reg <= wdat[`RTC_BIT_MAINS_RATE];
      end
   end

   // ==================================================
   // Sleep recovery cause
   // ==================================================
   // Captured when the wake reset fires; rst_i does not touch
   // it, so software can read it once running again.
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         sleep_cause_reg <= 1'b0;
      end else if (wake_reset_i) begin
         sleep_cause_reg <= alarm_reg;
      end else if (rd_ctrl) begin
         sleep_cause_reg <= 1'b0;
      end
   end

   // ==================================================
   // Alarm match enables
   // ==================================================
   always_ff @(posedge clk_i) begin
      if (por_i || rst_i) begin
         match_en_reg <= `RTC_RST_MATCH_EN;
      end else if (wr_match) begin
         match_en_reg <= wdat[3:0];
      end
   end

   // ==================================================
   // Event history
   // ==================================================
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         unlock_d_reg <= `RTC_RST_UNLOCK;
         tick_d_reg   <= 1'b0;
      end else begin
         unlock_d_reg <= unlock_reg;
         tick_d_reg   <= count_tick_o;
      end
   end

   // ==================================================
   // Outputs toward count and alarm registers
   // ==================================================
   // Tick is swallowed while counts are open for writing
   always_ff @(posedge clk_i) begin
      if (por_i || rst_i) begin
         count_tick_o <= 1'b0;
      end else begin
         count_tick_o <= sec_tick & ~unlock_reg;
      end
   end

   // Mirrors of control bits, each its own flop
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         osc_enable_o         <= 1'b1;
         count_write_permit_o <= `RTC_RST_UNLOCK;
         bcd_mode_o           <= 1'b0;
         match_enable_o       <= `RTC_RST_MATCH_EN;
      end else begin
         osc_enable_o         <= ~src_sel_reg;
         // Same permit gates century and alarm weekday writes
         count_write_permit_o <= unlock_reg;
         bcd_mode_o           <= bcd_reg;
         match_enable_o       <= match_en_reg;
      end
   end

   // Request withdrawn the cycle after a clearing read
   always_ff @(posedge clk_i) begin
      if (por_i || rst_i) begin
         alarm_irq_o <= 1'b0;
      end else begin
         alarm_irq_o <= alarm_reg & int_en_reg;
      end
   end

   // ==================================================
   // Read view
   // ==================================================
   // Alarm, reserved and cause bits take no write data
   always_comb begin
      ctrl_view                       = 8'h00;
      ctrl_view[`RTC_BIT_ALARM]       = alarm_reg;
      ctrl_view[`RTC_BIT_INT_EN]      = int_en_reg;
      ctrl_view[`RTC_BIT_BCD]         = bcd_reg;
      ctrl_view[`RTC_BIT_SRC_SEL]     = src_sel_reg;
      ctrl_view[`RTC_BIT_MAINS_RATE]  = mains_rate_reg;
      ctrl_view[`RTC_BIT_RSVD]        = `RTC_RSVD_VALUE;
      ctrl_view[`RTC_BIT_SLEEP_CAUSE] = sleep_cause_reg;
      ctrl_view[`RTC_BIT_UNLOCK]      = unlock_reg;
   end

   // ==================================================
   // Wishbone answer
   // ==================================================
   // One wait state: ack one edge after the request, then
   // low for a cycle even if the master keeps stb up.
   always_ff @(posedge clk_i) begin
      if (por_i || rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Data taken at the same edge; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (por_i || rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         if (hit_ctrl) begin
            wb_dat_o <= {24'h00_0000, ctrl_view};
         end else if (hit_match) begin
            wb_dat_o <= {28'h000_0000, match_en_reg};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

endmodule : rtc_control_status

// >>> design/rtc_ctrl_params.svh
`ifndef RTC_CTRL_PARAMS_SVH
`define RTC_CTRL_PARAMS_SVH

// ==================================================
// Register word indices (byte address is index * 4)
// ==================================================
`define RTC_ALARM_MATCH_IDX   8'hec
`define RTC_CONTROL_IDX       8'hed

// ==================================================
// Control register bit positions
// ==================================================
`define RTC_BIT_ALARM         7
`define RTC_BIT_INT_EN        6
`define RTC_BIT_BCD           5
`define RTC_BIT_SRC_SEL       4
`define RTC_BIT_MAINS_RATE    3
`define RTC_BIT_RSVD          2
`define RTC_BIT_SLEEP_CAUSE   1
`define RTC_BIT_UNLOCK        0

// ==================================================
// Reset values
// ==================================================
`define RTC_RST_INT_EN        1'b0
`define RTC_RST_UNLOCK        1'b0
`define RTC_RST_MATCH_EN      4'h0
`define RTC_RSVD_VALUE        1'b0

// ==================================================
// Time-base edges per one-second tick
// ==================================================
`define RTC_XTAL_HZ           16'd32768
`define RTC_MAINS_60_HZ       16'd60
`define RTC_MAINS_50_HZ       16'd50

`endif

// >>> design/rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;

   // ==================================================
   // Types
   // ==================================================
   // Time source choice
   typedef enum logic {
      SRC_XTAL = 1'b0,
      SRC_LINE = 1'b1
   } time_source_e;

   // Mains rate choice
   typedef enum logic {
      MAINS_60 = 1'b0,
      MAINS_50 = 1'b1
   } mains_rate_e;

   // Prescale count width
   typedef logic [15:0] prescale_t;

endpackage : rtc_ctrl_pkg

// >>> design/rtc_prescaler.sv
`timescale 1ns/1ps

// ==================================================
// Time-base prescale divider
// ==================================================
module rtc_prescaler #(
   parameter int W = 16    // Counter width
) (
   input  wire logic         clk_i,      // System clock
   input  wire logic         rst_i,      // Sync reset, active high
   input  wire logic         clear_i,    // Restart the divide
   input  wire logic         step_i,     // One source edge
   input  wire logic [W-1:0] divisor_i,  // Edges per tick
   output logic              tick_o      // One-cycle tick pulse
);

   logic [W-1:0] count_reg;  // Edges seen this second

   // Count edges, wrap at divisor
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_reg <= '0;
         tick_o    <= 1'b0;
      end else if (step_i) begin
         if (count_reg >= divisor_i - W'(1)) begin
            count_reg <= '0;
            tick_o    <= 1'b1;
         end else begin
            count_reg <= count_reg + W'(1);
            tick_o    <= 1'b0;
         end
      end else begin
         tick_o <= 1'b0;
      end
   end

endmodule : rtc_prescaler

// >>> test/rtc_control_status_asserts.sv
`timescale 1ns/1ps
`include "rtc_ctrl_params.svh"

// ==================================================
// Port checker for the control and status block
// ==================================================
module rtc_control_status_checker #(
   parameter int ADR_W = 10  // Byte address width
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             por_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic             osc_enable_o,
   input wire logic             count_tick_o,
   input wire logic             count_write_permit_o,
   input wire logic             bcd_mode_o,
   input wire logic [3:0]       match_enable_o,
   input wire logic             alarm_irq_o
);
   // Word addresses as byte addresses
   localparam logic [ADR_W-1:0] CTRL_A = ADR_W'({`RTC_CONTROL_IDX, 2'b00});
   localparam logic [ADR_W-1:0] MTCH_A = ADR_W'({`RTC_ALARM_MATCH_IDX, 2'b00});
   logic req;      // Request taken this edge
   logic wr_ctrl;  // Control write with lane 0
   logic wr_mtch;  // Match write with lane 0
   logic rd_ack;   // Control read answered
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_A;
   assign wr_mtch = req && wb_we_i && wb_sel_i[0] && wb_adr_i == MTCH_A;
   assign rd_ack = wb_ack_o && !wb_we_i && wb_adr_i == CTRL_A;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || por_i);

   // ==================================================
   // Bus answer
   // ==================================================
   ack_latency_a: assert property (req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   rsvd_zero_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[2])
      else $error("reserved control bits not zero");

   // ==================================================
   // Flag and request
   // ==================================================
   // Ticks and a recent lock may set the flag again, so they are excluded
   read_clears_a: assert property (rd_ack && !$past(count_tick_o, 2)
      && !$past(wr_ctrl, 2) |=> !alarm_irq_o)
      else $error("alarm request stayed after control read");
   rst_irq_a: assert property (@(posedge clk_i) disable iff (por_i)
      rst_i |=> !alarm_irq_o)
      else $error("alarm request survived system reset");
   rst_clear_a: assert property (@(posedge clk_i) disable iff (por_i)
      rst_i |-> ##2 (!count_write_permit_o && match_enable_o == 4'h0))
      else $error("permit or match enables survived reset");

   // ==================================================
   // Mode mirrors and count tick
   // ==================================================
   osc_follow_a: assert property ($past(wr_ctrl, 2) |->
      osc_enable_o == !$past(wb_dat_i[4], 2))
      else $error("oscillator enable does not follow source bit");
   mode_follow_a: assert property ($past(wr_ctrl, 2) |->
      bcd_mode_o == $past(wb_dat_i[5], 2) && count_write_permit_o == $past(wb_dat_i[0], 2))
      else $error("decimal or permit output does not follow write");
   match_follow_a: assert property ($past(wr_mtch, 2) |->
      match_enable_o == $past(wb_dat_i[3:0], 2))
      else $error("match enables do not follow write");
   tick_halt_a: assert property (count_write_permit_o && $past(count_write_permit_o)
      |-> !count_tick_o)
      else $error("count tick while counter halted");
   tick_pulse_a: assert property (count_tick_o |=> !count_tick_o)
      else $error("count tick longer than one cycle");

   tick_c: cover property (count_tick_o);
   irq_c: cover property (alarm_irq_o);
   write_c: cover property (wr_ctrl);
endmodule : rtc_control_status_checker

bind rtc_control_status rtc_control_status_checker #(.ADR_W(ADR_W)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_enable_o(osc_enable_o),
   .count_tick_o(count_tick_o), .count_write_permit_o(count_write_permit_o),
   .bcd_mode_o(bcd_mode_o), .match_enable_o(match_enable_o), .alarm_irq_o(alarm_irq_o));

// >>> test/rtc_time_source_model.sv
`timescale 1ns/1ps

// ==================================================
// Crystal and mains source model
// ==================================================
module rtc_time_source_model #(
   parameter int XTAL_HALF = 3,  // Crystal half period in clocks
   parameter int LINE_HALF = 4   // Mains half period in clocks
) (
   input  wire logic clk_i,         // System clock
   input  wire logic osc_enable_i,  // Oscillator on
   output logic      xtal_clk_o,    // Crystal pin
   output logic      line_freq_o    // Mains pin
);
   int xtal_cnt = 0;  // Crystal phase count
   int line_cnt = 0;  // Mains phase count
   initial begin
      xtal_clk_o = 1'b0;
      line_freq_o = 1'b0;
   end
   // Scaled-down rates: each level still lasts three clocks or more
   always @(posedge clk_i) begin
      if (!osc_enable_i) begin
         xtal_cnt <= 0;
         xtal_clk_o <= 1'b0;
      end else if (xtal_cnt == XTAL_HALF - 1) begin
         xtal_cnt <= 0;
         xtal_clk_o <= ~xtal_clk_o;
      end else begin
         xtal_cnt <= xtal_cnt + 1;
      end
   end
   // Mains is always present, whatever the source choice
   always @(posedge clk_i) begin
      if (line_cnt == LINE_HALF - 1) begin
         line_cnt <= 0;
         line_freq_o <= ~line_freq_o;
      end else begin
         line_cnt <= line_cnt + 1;
      end
   end
endmodule : rtc_time_source_model

// >>> test/testbench.sv
`timescale 1ns/1ps

// ==================================================
// Control and status bench
// ==================================================
module testbench;
   localparam logic [9:0] CTRL_A = 10'h3b4;  // Control word
   localparam logic [9:0] MTCH_A = 10'h3b0;  // Match enables
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        por_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0;
   logic [9:0]  adr = 10'h0;
   logic [3:0]  sel = 4'hf, fmatch = 4'h0, men;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic        ack, xtal, line, osc, tick, permit, bcd, irq;
   int          miscompares = 0, tests_run = 0, rises = 0, ticks = 0;

   always #25 clk_i = ~clk_i;  // 20 MHz
   always @(posedge line) rises++;  // Mains edges
   always @(posedge clk_i) if (tick === 1'b1) ticks++;  // Count ticks

   rtc_control_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .xtal_clk_i(xtal), .line_freq_i(line),
      .osc_enable_o(osc), .field_match_i(fmatch), .wake_reset_i(wake),
      .count_tick_o(tick), .count_write_permit_o(permit), .bcd_mode_o(bcd),
      .match_enable_o(men), .alarm_irq_o(irq));
   rtc_time_source_model src_u (.clk_i(clk_i), .osc_enable_i(osc), .xtal_clk_o(xtal),
      .line_freq_o(line));

   // ==================================================
   // Tasks
   // ==================================================
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One classic cycle, held until ack is sampled
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      chk("ack", 32'h1, {31'h0, ack});
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [7:0] e, input string nm);
      xfer(1'b0, a, 32'h0);
      chk(nm, {24'h0, e}, rdat);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle
   // Unlock then lock, so the alarm is evaluated
   task automatic lock(input logic [7:0] v);
      wr(CTRL_A, v | 8'h01);
      wr(CTRL_A, v);
      idle(6);
   endtask : lock
   // Mains edges from divider restart to the count tick
   task automatic mains(input logic m, input int n);
      int k;
      wr(CTRL_A, {4'h1, m, 3'h0});
      rises = 0;
      k = 0;
      while (tick !== 1'b1 && k < 2000) begin
         @(posedge clk_i);
         k++;
      end
      tests_run++;
      if (rises < n - 2 || rises > n + 1) begin
         miscompares++;
         $display("ERROR mains edges per tick expected %0d seen %0d", n, rises);
      end
   endtask : mains
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // ==================================================
   // Sequence
   // ==================================================
   initial begin
      idle(4);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      idle(1);
      rd(CTRL_A, 8'h00, "ctrl reset");
      rd(MTCH_A, 8'h00, "match reset");
      chk("osc on", 32'h1, {31'h0, osc});
      wr(CTRL_A, 8'hff);
      idle(2);
      chk("modes", 32'h3, {29'h0, osc, bcd, permit});
      rd(CTRL_A, 8'h79, "read only bits");
      sel <= 4'he;
      wr(CTRL_A, 8'h00);
      sel <= 4'hf;
      rd(CTRL_A, 8'h79, "lane refused");
      wr(10'h100, 8'hff);
      rd(10'h100, 8'h00, "unmapped");
      ticks = 0;
      idle(700);
      chk("halted", 32'h0, ticks);
      for (int m = 0; m < 2; m++) mains(m[0], m ? 50 : 60);
      wr(CTRL_A, 8'h40);
      idle(2);
      chk("osc back", 32'h1, {31'h0, osc});
      wr(MTCH_A, 8'h03);
      fmatch <= 4'h3;
      idle(10);
      chk("match enables", 32'h3, {28'h0, men});
      rd(CTRL_A, 8'h40, "no event");
      fmatch <= 4'h1;
      lock(8'h40);
      rd(CTRL_A, 8'h40, "partial match");
      fmatch <= 4'h3;
      lock(8'h40);
      chk("irq up", 32'h1, {31'h0, irq});
      rd(CTRL_A, 8'hc0, "alarm set");
      idle(2);
      chk("irq down", 32'h0, {31'h0, irq});
      rd(CTRL_A, 8'h40, "alarm cleared");
      lock(8'h00);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(CTRL_A, 8'h80, "masked alarm");
      lock(8'h68);
      wake <= 1'b1;
      idle(1);
      wake <= 1'b0;
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      idle(1);
      chk("irq reset", 32'h0, {31'h0, irq});
      rd(CTRL_A, 8'haa, "after reset");
      rd(MTCH_A, 8'h00, "match after reset");
      rd(CTRL_A, 8'h28, "cause cleared");
      wake <= 1'b1;
      idle(1);
      wake <= 1'b0;
      rd(CTRL_A, 8'h28, "quiet wake");
      wr(MTCH_A, 8'h03);
      mains(1'b0, 60);
      rd(CTRL_A, 8'h90, "tick alarm");
      summarize();
   end

   // Whole run is a few thousand cycles
   initial begin
      idle(10000);
      miscompares++;
      summarize();
   end
endmodule : testbench
